// ==== core/irc_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, clk at 250 MHz.
// Notes: Each register takes one aligned word.
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH

// Register byte offsets.
`define IRC_OFF_CTRL    6'h00
`define IRC_OFF_XSTART  6'h04
`define IRC_OFF_YSTART  6'h08
`define IRC_OFF_GAIN    6'h0c
`define IRC_OFF_DACRAW  6'h10
`define IRC_OFF_DACFINE 6'h14
`define IRC_OFF_DACDARK 6'h18
`define IRC_OFF_PIXCNT  6'h1c
`define IRC_OFF_STATUS  6'h20

// Control register field positions.
`define IRC_CTRL_SUB_LSB  0
`define IRC_CTRL_NDR_BIT  3
`define IRC_CTRL_ONE_BIT  4
`define IRC_CTRL_STBY_BIT 5
`define IRC_CTRL_SADC_BIT 6
`define IRC_CTRL_CAL_BIT  7

// Status register field positions.
`define IRC_STAT_COL_LSB  0
`define IRC_STAT_ROW_LSB  12
`define IRC_STAT_BLK_BIT  24
`define IRC_STAT_RD_BIT   25

// Reset values.
`define IRC_RST_PIXCNT 12'h8a2
`define IRC_RST_GAIN   4'h0
`define IRC_RST_DAC    8'h80

// Address grid and start-coordinate limits.
`define IRC_X_BLOCK  24
`define IRC_X_STARTS 99
`define IRC_Y_STARTS 138

// Timing: printed figures, then derived clock counts.
`define IRC_CLK_PS      4000
`define IRC_PIX_PS      25000
`define IRC_BLANK_PS    7200000
`define IRC_PIX_CYC   ((`IRC_PIX_PS + `IRC_CLK_PS - 1) / `IRC_CLK_PS)
`define IRC_BLANK_CYC ((`IRC_BLANK_PS + `IRC_CLK_PS - 1) / `IRC_CLK_PS)

`endif

// ==== core/irc_pkg.sv ====
// Purpose: Types shared by the readout control block.
// Assumes: Included alongside irc_params.svh.
// Notes: All state of the top module is one packed struct.
package irc_pkg;

   typedef enum logic [2:0] {
      IRC_IDLE  = 3'b001,
      IRC_BLANK = 3'b010,
      IRC_READ  = 3'b100
   } irc_state_t;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } irc_avreq_t;

   // Avalon-MM answer to the master.
   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } irc_avrsp_t;

   // Configuration written by software.
   typedef struct packed {
      logic [2:0] subMode;
      logic nondestructiveMode;
      logic oneOut;
      logic ampStandby;
      logic singleAdc;
      logic calibrate;
      logic [6:0] xStart;
      logic [7:0] yStart;
      logic [3:0] gain;
      logic [7:0] dacRaw;
      logic [7:0] dacFine;
      logic [7:0] dacDark;
      logic [11:0] pixCount;
   } irc_cfg_t;

   // Pin-side controls of the array and amplifier.
   typedef struct packed {
      logic [11:0] colAddr;
      logic [11:0] rowAddr;
      logic pixelStrobe;
      logic busSel;
      logic adcSel;
      logic loadX;
      logic loadY;
      logic blanking;
      logic darkOnBus;
      logic resetBusTie;
      logic singleOut;
      logic path2Standby;
      logic ampStandby;
      logic [3:0] gain;
      logic [7:0] dacRaw;
      logic [7:0] dacFine;
      logic [7:0] dacDark;
   } irc_pins_t;

endpackage

// ==== core/irc_readout_ctrl.sv ====
// Purpose: Readout addressing and output-path control of a pixel array.
// Assumes: Frame and row pulses come from a camera controller off-domain.
// Notes: Registers on Avalon-MM with waitrequest; one clock, clock enable.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "irc_params.svh"

// Behaviour
// - Frame start loads the row start and each row pulse loads column start.
// - A row lasts one blanking interval plus one pixel period per pixel.
// - Two outputs after reset; single-output merges and idles path two.
// - The standby bit idles the whole output amplifier.
// - The gain stage takes a 4-bit code, 0000 lowest to 1111 highest.
// - Each offset DAC takes a linear 8-bit code.
// - Nondestructive mode ties both reset buses to the trim DAC output.
// - During amplifier calibration the dark level is driven onto the buses.
// - Even and odd columns go to two converters, or all to one.
// - Each sub-sampling mode reads two adjacent pixels then steps 2 to 12.
// - Addressing repeats in 24-wide blocks with 99 x and 138 y starts.
// - Columns are addressed in pairs, rows one at a time.
// - The nondestructive bit picks double-sampled or nondestructive read.
// - After the first row pulse of a frame, row pulses alternate next row and mode step; every row pulse not taken with a frame pulse starts row blanking.
module irc_readout_ctrl (
   input wire logic clk, // 250 MHz clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic clkEn, // Clock enable; state holds while low.
   input wire irc_pkg::irc_avreq_t avReq, // Avalon-MM request.
   output irc_pkg::irc_avrsp_t avRsp, // Avalon-MM answer.
   input wire logic frameStartPin, // Frame-start pulse from the controller.
   input wire logic rowClockPin, // Row-clock pulse from the controller.
   output irc_pkg::irc_pins_t pins // Array and amplifier controls.
);
   import irc_pkg::*;

   // Timing counts in clocks and the column grid, sized to the counters.
   localparam logic [11:0] PIX_CYC = 12'(`IRC_PIX_CYC);
   localparam logic [11:0] BLANK_CYC = 12'(`IRC_BLANK_CYC);
   localparam logic [11:0] X_BLOCK = 12'(`IRC_X_BLOCK);

   // All state of the block is one packed struct, filled by one process.
   typedef struct packed {
      irc_state_t state;
      irc_cfg_t cfg;
      irc_pins_t pins;
      irc_avrsp_t rsp;
      logic [1:0] fsSync;
      logic [1:0] rcSync;
      logic fsPrev;
      logic rcPrev;
      logic rowPhase;
      // Set by frame start, so the first row pulse keeps the start row.
      logic firstRow;
      logic [11:0] timer;
      logic [11:0] pixLeft;
   } irc_regs_t;

   irc_regs_t cur_ff;
   irc_regs_t nxt_cur;

   // Address advance after a pair of adjacent pixels, per sub-sample mode.
   // Any code with the top bit set takes the widest step, twelve.
   function automatic logic [11:0] stepOf(input logic [2:0] mode);
      logic [11:0] s;
      s = 12'h00c;
      unique case (mode)
         3'b000: s = 12'h002;
         3'b001: s = 12'h004;
         3'b010: s = 12'h006;
         3'b011: s = 12'h008;
         default: s = 12'h00c;
      endcase
      return s;
   endfunction

   // Register read mux; unmapped offsets read as zero.
   // Status bits are live, so a read shows the sequencer as it stands.
   function automatic logic [31:0] readMux(input irc_regs_t r,
                                           input logic [5:0] a);
      logic [31:0] d;
      d = 32'h0;
      unique case (a)
         `IRC_OFF_CTRL: d = {24'h0, r.cfg.calibrate, r.cfg.singleAdc,
            r.cfg.ampStandby, r.cfg.oneOut, r.cfg.nondestructiveMode,
            r.cfg.subMode};
         `IRC_OFF_XSTART: d = {25'h0, r.cfg.xStart};
         `IRC_OFF_YSTART: d = {24'h0, r.cfg.yStart};
         `IRC_OFF_GAIN: d = {28'h0, r.cfg.gain};
         `IRC_OFF_DACRAW: d = {24'h0, r.cfg.dacRaw};
         `IRC_OFF_DACFINE: d = {24'h0, r.cfg.dacFine};
         `IRC_OFF_DACDARK: d = {24'h0, r.cfg.dacDark};
         `IRC_OFF_PIXCNT: d = {20'h0, r.cfg.pixCount};
         `IRC_OFF_STATUS: d = {6'h0, r.state == IRC_READ,
            r.state == IRC_BLANK, r.pins.rowAddr, r.pins.colAddr};
         default: d = 32'h0;
      endcase
      return d;
   endfunction

   // Next-state logic for the bus slave, the sequencer and the outputs.
   // Every output leaves through cur_ff; the configuration pins change one clock
   // after cfg, while blanking and darkOnBus change with the state and adcSel with busSel.
   // Logic downstream counts on that single cycle of latency.
   // A frame pulse always wins over a row pulse in the same cycle, and a
   // row pulse that arrives in the middle of a row restarts blanking.
   always_comb begin
      logic fsEdge;
      logic rcEdge;
      logic take;
      logic [11:0] step;
      fsEdge = 1'b0;
      rcEdge = 1'b0;
      take = 1'b0;
      step = 12'h0;
      nxt_cur = cur_ff;

      // Pins pass two flip-flops; edges are taken from the second stage.
      // Only the second stage feeds the edge detector, so a metastable
      // first stage never reaches the sequencer.
      // The previous-value flops reset low, the idle level of both pins,
      // so no false edge follows reset.
      nxt_cur.fsSync = {cur_ff.fsSync[0], frameStartPin};
      nxt_cur.rcSync = {cur_ff.rcSync[0], rowClockPin};
      nxt_cur.fsPrev = cur_ff.fsSync[1];
      nxt_cur.rcPrev = cur_ff.rcSync[1];
      fsEdge = cur_ff.fsSync[1] & ~cur_ff.fsPrev;
      rcEdge = cur_ff.rcSync[1] & ~cur_ff.rcPrev;
      step = stepOf(cur_ff.cfg.subMode);

      // Avalon slave: one wait cycle, then the access completes.
      // The request is looked at while waitrequest is high, the answer is
      // registered, and the write lands at the edge where the master sees
      // waitrequest low.
      // A master that keeps its request up past that edge starts another.
      take = (avReq.read | avReq.write) & ~cur_ff.rsp.waitrequest;
      nxt_cur.rsp.waitrequest = 1'b1;
      if ((avReq.read | avReq.write) & cur_ff.rsp.waitrequest) begin
         nxt_cur.rsp.waitrequest = 1'b0;
         // Read data is captured with the answer and held until the next.
         nxt_cur.rsp.readdata = readMux(cur_ff, avReq.address);
      end
      // Writes to unmapped offsets and to the status word are dropped.
      if (take & avReq.write) begin
         unique case (avReq.address)
            `IRC_OFF_CTRL: begin
               nxt_cur.cfg.subMode =
                  avReq.writedata[`IRC_CTRL_SUB_LSB +: 3];
               nxt_cur.cfg.nondestructiveMode =
                  avReq.writedata[`IRC_CTRL_NDR_BIT];
               nxt_cur.cfg.oneOut = avReq.writedata[`IRC_CTRL_ONE_BIT];
               nxt_cur.cfg.ampStandby = avReq.writedata[`IRC_CTRL_STBY_BIT];
               nxt_cur.cfg.singleAdc = avReq.writedata[`IRC_CTRL_SADC_BIT];
               nxt_cur.cfg.calibrate = avReq.writedata[`IRC_CTRL_CAL_BIT];
            end
            `IRC_OFF_XSTART: begin
               // Start indices beyond the array clamp to the last one.
               // The index counts 24-pixel blocks, so it lands on the grid.
               if (avReq.writedata[6:0] < 7'(`IRC_X_STARTS)) begin
                  nxt_cur.cfg.xStart = avReq.writedata[6:0];
               end else begin
                  nxt_cur.cfg.xStart = 7'(`IRC_X_STARTS - 1);
               end
            end
            `IRC_OFF_YSTART: begin
               // Row starts may be any row inside the array.
               if (avReq.writedata[7:0] < 8'(`IRC_Y_STARTS)) begin
                  nxt_cur.cfg.yStart = avReq.writedata[7:0];
               end else begin
                  nxt_cur.cfg.yStart = 8'(`IRC_Y_STARTS - 1);
               end
            end
            // Codes and DAC words pass straight through to the pins.
            `IRC_OFF_GAIN: nxt_cur.cfg.gain = avReq.writedata[3:0];
            `IRC_OFF_DACRAW: nxt_cur.cfg.dacRaw = avReq.writedata[7:0];
            `IRC_OFF_DACFINE: nxt_cur.cfg.dacFine = avReq.writedata[7:0];
            `IRC_OFF_DACDARK: nxt_cur.cfg.dacDark = avReq.writedata[7:0];
            `IRC_OFF_PIXCNT: nxt_cur.cfg.pixCount = avReq.writedata[11:0];
            default: ;
         endcase
      end

      // Sequencer: row pulse, blanking, then one pixel per pixel period.
      // The pixel period is rounded up to whole clocks, so a row is never
      // shorter than the nominal blanking plus pixel time.
      // Strobes last one cycle; they are cleared unless set again below.
      nxt_cur.pins.loadX = 1'b0;
      nxt_cur.pins.loadY = 1'b0;
      nxt_cur.pins.pixelStrobe = 1'b0;
      if (fsEdge) begin
         nxt_cur.pins.rowAddr = 12'(cur_ff.cfg.yStart);
         nxt_cur.pins.loadY = 1'b1;
         nxt_cur.rowPhase = 1'b0;
         nxt_cur.firstRow = 1'b1;
         nxt_cur.state = IRC_IDLE;
      end else if (rcEdge) begin
         // Rows go one by one: two adjacent rows, then the mode step.
         // The first row pulse of a frame reads the programmed start row.
         if (cur_ff.firstRow) begin
            nxt_cur.rowPhase = 1'b0;
            nxt_cur.firstRow = 1'b0;
         end else if (!cur_ff.rowPhase) begin
            nxt_cur.pins.rowAddr = cur_ff.pins.rowAddr + 12'h001;
            nxt_cur.rowPhase = 1'b1;
         end else begin
            nxt_cur.pins.rowAddr =
               cur_ff.pins.rowAddr + step - 12'h001;
            nxt_cur.rowPhase = 1'b0;
         end
         // Each row restarts at the programmed column block.
         nxt_cur.pins.colAddr =
            12'(cur_ff.cfg.xStart * X_BLOCK);
         nxt_cur.pins.loadX = 1'b1;
         nxt_cur.pins.busSel = 1'b0;
         nxt_cur.timer = BLANK_CYC - 12'h001;
         nxt_cur.pixLeft = cur_ff.cfg.pixCount;
         nxt_cur.state = IRC_BLANK;
      end else begin
         unique case (cur_ff.state)
            IRC_IDLE: ;
            IRC_BLANK: begin
               // A zero pixel count ends the row after blanking.
               if (cur_ff.timer == 12'h0) begin
                  nxt_cur.timer = PIX_CYC - 12'h001;
                  nxt_cur.state =
                     (cur_ff.pixLeft == 12'h0) ? IRC_IDLE : IRC_READ;
               end else begin
                  nxt_cur.timer = cur_ff.timer - 12'h001;
               end
            end
            IRC_READ: begin
               if (cur_ff.timer == 12'h0) begin
                  // One pixel per period; the pair advances after two.
                  // busSel shows the bus of the pixel after this strobe.
                  nxt_cur.pins.pixelStrobe = 1'b1;
                  nxt_cur.pixLeft = cur_ff.pixLeft - 12'h001;
                  nxt_cur.timer = PIX_CYC - 12'h001;
                  nxt_cur.pins.busSel = ~cur_ff.pins.busSel;
                  if (cur_ff.pins.busSel) begin
                     nxt_cur.pins.colAddr =
                        cur_ff.pins.colAddr + step;
                  end
                  // The last pixel of the row returns to idle.
                  if (cur_ff.pixLeft == 12'h001) begin
                     nxt_cur.state = IRC_IDLE;
                  end
               end else begin
                  nxt_cur.timer = cur_ff.timer - 12'h001;
               end
            end
            // An illegal state code falls back to idle.
            default: nxt_cur.state = IRC_IDLE;
         endcase
      end

      // Converter select follows the column parity unless one is used.
      // With one converter every pixel goes to the even-column input.
      nxt_cur.pins.adcSel = cur_ff.cfg.singleAdc ? 1'b0 :
         nxt_cur.pins.busSel;

      // Amplifier and output-path controls.
      // Apart from blanking and the state term of darkOnBus, these follow the configuration one clock late; software
      // should change them only between frames so a row never sees a mix.
      // Path two idles in single-output mode and with the whole amplifier.
      nxt_cur.pins.blanking = (nxt_cur.state == IRC_BLANK);
      nxt_cur.pins.darkOnBus = (nxt_cur.state == IRC_BLANK) |
         cur_ff.cfg.calibrate;
      nxt_cur.pins.resetBusTie = cur_ff.cfg.nondestructiveMode;
      nxt_cur.pins.singleOut = cur_ff.cfg.oneOut;
      nxt_cur.pins.path2Standby = cur_ff.cfg.oneOut |
         cur_ff.cfg.ampStandby;
      nxt_cur.pins.ampStandby = cur_ff.cfg.ampStandby;
      nxt_cur.pins.gain = cur_ff.cfg.gain;
      nxt_cur.pins.dacRaw = cur_ff.cfg.dacRaw;
      nxt_cur.pins.dacFine = cur_ff.cfg.dacFine;
      nxt_cur.pins.dacDark = cur_ff.cfg.dacDark;
   end

   // State register with synchronous reset and clock enable.
   // Reset wins over the clock enable, so a reset taken while the enable
   // is low still returns the block to its idle state.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur_ff <= '0;
         cur_ff.state <= IRC_IDLE;
         cur_ff.rsp.waitrequest <= 1'b1;
         cur_ff.cfg.pixCount <= `IRC_RST_PIXCNT;
         cur_ff.cfg.gain <= `IRC_RST_GAIN;
         cur_ff.cfg.dacRaw <= `IRC_RST_DAC;
         cur_ff.cfg.dacFine <= `IRC_RST_DAC;
         cur_ff.cfg.dacDark <= `IRC_RST_DAC;
         cur_ff.pins.gain <= `IRC_RST_GAIN;
         cur_ff.pins.dacRaw <= `IRC_RST_DAC;
         cur_ff.pins.dacFine <= `IRC_RST_DAC;
         cur_ff.pins.dacDark <= `IRC_RST_DAC;
      end else if (clkEn) begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs come straight from the state register.
   // No logic sits between the state flops and the ports.
   assign avRsp = cur_ff.rsp;
   assign pins = cur_ff.pins;

endmodule

// ==== sim/irc_readout_ctrl_props.sv ====
// Purpose: Concurrent checks on the readout control block's ports.
// Assumes: One clock domain; clock enable held high in normal runs.
// Notes: Bound to the top module after the module below.
`timescale 1ns/10ps
module irc_readout_ctrl_props (
   input wire logic clk, // Clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic clkEn, // Clock enable.
   input wire irc_pkg::irc_avreq_t avReq, // Bus request.
   input wire irc_pkg::irc_avrsp_t avRsp, // Bus answer.
   input wire logic frameStartPin, // Frame pulse.
   input wire logic rowClockPin, // Row pulse.
   input wire irc_pkg::irc_pins_t pins // Array controls.
);
   import irc_pkg::*;
   logic [11:0] blankCnt_ff;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Counts the cycles of the current blanking interval.
   always_ff @(posedge clk) begin
      if (sys_rst || !pins.blanking) begin
         blankCnt_ff <= 12'h000;
      end else if (clkEn) begin
         blankCnt_ff <= blankCnt_ff + 12'h001;
      end
   end

   // Output path, blanking and load relations.
   chk_single_idles: assert property (
      pins.singleOut |-> pins.path2Standby) else $error("path two awake");
   chk_stby_idles: assert property (
      pins.ampStandby |-> pins.path2Standby) else $error("standby leak");
   chk_blank_dark: assert property (
      pins.blanking |-> pins.darkOnBus) else $error("no dark level");
   chk_blank_len: assert property (
      $fell(pins.blanking) |-> blankCnt_ff == 12'h708)
      else $error("blanking length wrong");
   chk_pixel_gap: assert property (
      pins.pixelStrobe |=> !pins.pixelStrobe [*6])
      else $error("pixel period short");
   chk_strobe_read: assert property (
      pins.pixelStrobe |-> !pins.blanking) else $error("strobe in blank");
   chk_row_load: assert property (
      $rose(rowClockPin) && !frameStartPin |-> ##[3:5] pins.loadX)
      else $error("row pulse not taken");
   chk_frame_load: assert property (
      $rose(frameStartPin) |-> ##[3:5] pins.loadY)
      else $error("frame pulse not taken");
   chk_col_grid: assert property (
      pins.loadX |-> pins.colAddr % 24 == 0 && pins.blanking)
      else $error("column start off grid");
   chk_row_range: assert property (
      pins.loadY |-> pins.rowAddr < 12'h08a) else $error("row start range");
endmodule

bind irc_readout_ctrl irc_readout_ctrl_props u_props (.clk(clk),
   .sys_rst(sys_rst), .clkEn(clkEn), .avReq(avReq), .avRsp(avRsp),
   .frameStartPin(frameStartPin), .rowClockPin(rowClockPin), .pins(pins));

// ==== sim/irc_cam_ctl.sv ====
// Purpose: Camera controller model making frame and row pulses.
// Assumes: Pulses are long enough for a two-stage synchroniser.
// Notes: The bench calls pulse() to issue one pulse.
`timescale 1ns/10ps
module irc_cam_ctl (
   input wire logic clk, // Clock.
   output logic frameStartPin, // Frame pulse.
   output logic rowClockPin // Row pulse.
);
   // Both pins rest low until asked.
   initial begin
      frameStartPin = 1'b0;
      rowClockPin = 1'b0;
   end

   // Low gap, three cycles high, then low again.
   task automatic pulse(input logic isFrame);
      repeat (3) @(posedge clk);
      if (isFrame) begin
         frameStartPin <= 1'b1;
      end else begin
         rowClockPin <= 1'b1;
      end
      repeat (3) @(posedge clk);
      frameStartPin <= 1'b0;
      rowClockPin <= 1'b0;
   endtask
endmodule

// ==== sim/tb_irc_readout_ctrl.sv ====
// Purpose: Self-checking bench of the readout control block.
// Assumes: Clock enable held high; pulses come from the model.
// Notes: Registers are reached over Avalon-MM tasks.
`timescale 1ns/10ps
`include "irc_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_irc_readout_ctrl;
   import irc_pkg::*;
   logic clk, sys_rst, clkEn, frameStartPin, rowClockPin;
   irc_avreq_t avReq;
   irc_avrsp_t avRsp;
   irc_pins_t pins;
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] q;

   irc_readout_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .avReq(avReq), .avRsp(avRsp), .frameStartPin(frameStartPin),
      .rowClockPin(rowClockPin), .pins(pins));
   irc_cam_ctl u_cam (.clk(clk), .frameStartPin(frameStartPin),
      .rowClockPin(rowClockPin));

   // Clock, start values and reset.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1;
      clkEn = 1'b1;
      avReq = '0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
   end

   // Reports the counts and ends the run.
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One bus access, held until waitrequest is seen low.
   task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      avReq.address <= a;
      avReq.write <= w;
      avReq.read <= !w;
      avReq.writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avRsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) bad_count++;
      q = avRsp.readdata;
      avReq.read <= 1'b0;
      avReq.write <= 1'b0;
      @(posedge clk);
   endtask

   // Issues a row pulse and waits for it to be taken.
   task automatic row_pulse;
      int n;
      fork
         u_cam.pulse(1'b0);
         begin
            n = 0;
            while (pins.loadX !== 1'b1 && n < 30) begin
               @(posedge clk);
               n++;
            end
         end
      join
   endtask

   // Reset values, control bits, codes, clamps and an unmapped read.
   task automatic t_regs;
      av(`IRC_OFF_GAIN, 1'b0, 0); `CHK(q, 32'h0)
      av(`IRC_OFF_DACRAW, 1'b0, 0); `CHK(q, 32'h80)
      av(`IRC_OFF_PIXCNT, 1'b0, 0); `CHK(q, 32'h8a2)
      av(6'h3c, 1'b0, 0); `CHK(q, 32'h0)
      `CHK(pins.singleOut, 1'b0)
      for (int b = 3; b < 8; b++) begin
         av(`IRC_OFF_CTRL, 1'b1, 32'h1 << b);
         repeat (2) @(posedge clk);
         `CHK(pins.resetBusTie, 1'(b == 3))
         `CHK(pins.singleOut, 1'(b == 4))
         `CHK(pins.ampStandby, 1'(b == 5))
         `CHK(pins.path2Standby, 1'(b == 4 || b == 5))
         `CHK(pins.darkOnBus, 1'(b == 7))
      end
      av(`IRC_OFF_GAIN, 1'b1, 32'hf);
      av(`IRC_OFF_DACRAW, 1'b1, 32'hff);
      av(`IRC_OFF_DACDARK, 1'b1, 32'h0);
      repeat (2) @(posedge clk);
      `CHK(pins.gain, 4'hf)
      `CHK({pins.dacRaw, pins.dacDark}, 16'hff00)
      av(`IRC_OFF_XSTART, 1'b1, 32'h63);
      av(`IRC_OFF_XSTART, 1'b0, 0); `CHK(q, 32'h62)
      av(`IRC_OFF_YSTART, 1'b1, 32'hc8);
      av(`IRC_OFF_YSTART, 1'b0, 0); `CHK(q, 32'h89)
      $display("test regs done");
   endtask

   // One frame in a sub-sampling mode, checking addresses and timing.
   task automatic t_rows(input logic [2:0] mode, input logic single);
      int n;
      logic [11:0] step;
      step = mode[2] ? 12'h00c : ({10'h0, mode[1:0]} + 12'h001) << 1;
      av(`IRC_OFF_CTRL, 1'b1, {25'h0, single, 3'h0, mode});
      u_cam.pulse(1'b1);
      row_pulse();
      `CHK(pins.colAddr, 12'h030)
      `CHK(pins.rowAddr, 12'h005)
      n = 0;
      while (pins.blanking === 1'b1 && n < 3000) begin
         n++;
         @(posedge clk);
      end
      `CHK(n, 1800)
      for (int k = 0; k < 4; k++) begin
         n = 0;
         while (pins.pixelStrobe !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
         end
         `CHK(pins.colAddr, 12'h030 + step * 12'((k + 1) / 2))
         `CHK(pins.adcSel, single ? 1'b0 : 1'(k % 2 == 0))
         @(posedge clk);
      end
      if (mode == 3'h0) begin
         row_pulse();
         `CHK(pins.rowAddr, 12'h006)
         n = 0;
         while (pins.blanking === 1'b1 && n < 3000) begin
            n++;
            @(posedge clk);
         end
         `CHK(n, 1800)
         repeat (40) @(posedge clk);
      end
      $display("test rows mode %0d done", mode);
   endtask

   // Main sequence.
   initial begin
      wait (sys_rst === 1'b0);
      @(posedge clk);
      t_regs();
      av(`IRC_OFF_XSTART, 1'b1, 32'h2);
      av(`IRC_OFF_YSTART, 1'b1, 32'h5);
      av(`IRC_OFF_PIXCNT, 1'b1, 32'h4);
      for (int m = 0; m < 5; m++) begin
         t_rows(3'(m), 1'(m == 4));
      end
      tally_and_finish();
   end

   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
